//--- rtl/gexf_top.v
// Function
// - unmasked detector data compared with exit threshold
// - exit also requires persistence filter agreement
// - zero threshold blocks exit until mode cleared
// - FIFO level reaching threshold raises enabled interrupt
// - level codes select 1, 4, 8, 16 datasets
// - four-bit mask selects participating detectors
// - mask bits map east, west, south, north
// - zero mask includes all four detectors
// - mask bits exclude detectors independently
// - exit at persistence count 1, 2, 4, 7
`timescale 1ns/1ps
`default_nettype none
`include "gexf_defs.vh"

module gexf_top #(
    parameter DW         = 8,
    parameter LW         = 6,
    parameter FIFO_DEPTH = 32
) (
    input  wire           clk,
    input  wire           arst_n,
    input  wire           ce,
    input  wire           wb_cyc_i,
    input  wire           wb_stb_i,
    input  wire           wb_we_i,
    input  wire [3:0]     wb_adr_i,
    input  wire [3:0]     wb_sel_i,
    input  wire [31:0]    wb_dat_i,
    output reg  [31:0]    wb_dat_o,
    output reg            wb_ack_o,
    input  wire           gesture_enter,
    input  wire           det_valid,
    input  wire [DW-1:0]  det_north,
    input  wire [DW-1:0]  det_south,
    input  wire [DW-1:0]  det_west,
    input  wire [DW-1:0]  det_east,
    input  wire           fifo_push,
    input  wire           fifo_pop,
    output reg            gesture_active,
    output reg            gesture_exit,
    output reg            fifo_irq
);
    localparam [1:0] ST_IDLE   = 2'b01;
    localparam [1:0] ST_ACTIVE = 2'b10;

    // Reset release synchroniser
    reg rst_meta_q;
    reg rst_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    // Registers
    reg  [DW-1:0] thresh_q;
    reg  [7:0]    ctrl_q;
    reg  [1:0]    mode_q;
    reg  [1:0]    state_q;
    reg  [1:0]    state_d;
    reg  [2:0]    end_cnt_q;
    reg  [2:0]    end_cnt_d;
    reg  [2:0]    pers_need;
    reg  [LW-1:0] irq_count;
    reg  [31:0]   rd_data;

    wire [LW-1:0] fifo_level;
    wire          gesture_end;
    wire          exit_now;

    wire [1:0] lvl_code  = ctrl_q[`GEXF_FIFO_LVL_HI:`GEXF_FIFO_LVL_LO];
    wire [3:0] exit_mask = ctrl_q[`GEXF_MASK_HI:`GEXF_MASK_LO];
    wire [1:0] pers_code = ctrl_q[`GEXF_PERS_HI:`GEXF_PERS_LO];
    wire       mode_on   = mode_q[`GEXF_MODE_ACTIVE];
    wire       irq_en    = mode_q[`GEXF_MODE_IRQ_EN];
    wire       in_active = state_q[1];

    // Bus request decode
    wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
    wire [1:0] wb_idx = wb_adr_i[3:2];

    // Detector vector packs as {N,S,W,E}: mask bit 0 is east
    gexf_exit_detect #(
        .NDET (4),
        .DW   (DW)
    ) u_exit (
        .det_data    ({det_north, det_south, det_west, det_east}),
        .det_mask    (exit_mask),
        .threshold   (thresh_q),
        .gesture_end (gesture_end)
    );

    gexf_fifo_level #(
        .LW    (LW),
        .DEPTH (FIFO_DEPTH)
    ) u_level (
        .clk     (clk),
        .rst_n   (rst_q),
        .ce      (ce),
        .clear   (~mode_on),
        .push    (fifo_push),
        .pop     (fifo_pop),
        .level_q (fifo_level)
    );

    // Persistence decode
    always @* begin
        case (pers_code)
            `GEXF_PERS_CODE_1: pers_need = `GEXF_PERS_NEED_1;
            `GEXF_PERS_CODE_2: pers_need = `GEXF_PERS_NEED_2;
            `GEXF_PERS_CODE_4: pers_need = `GEXF_PERS_NEED_4;
            default:           pers_need = `GEXF_PERS_NEED_7;
        endcase
    end

    // FIFO interrupt level decode
    always @* begin
        case (lvl_code)
            `GEXF_LVL_CODE_1: irq_count = `GEXF_LVL_COUNT_1;
            `GEXF_LVL_CODE_4: irq_count = `GEXF_LVL_COUNT_4;
            `GEXF_LVL_CODE_8: irq_count = `GEXF_LVL_COUNT_8;
            default:          irq_count = `GEXF_LVL_COUNT_16;
        endcase
    end

    // Consecutive end occurrences, one per detection cycle
    always @* begin
        end_cnt_d = end_cnt_q;
        if (!in_active) begin
            end_cnt_d = 3'h0;
        end else if (det_valid) begin
            if (!gesture_end) begin
                end_cnt_d = 3'h0;
            end else if (end_cnt_q != `GEXF_PERS_NEED_7) begin
                end_cnt_d = end_cnt_q + 3'h1;
            end
        end
    end

    // Threshold hit alone is not enough; the filter must agree
    assign exit_now = in_active & det_valid & gesture_end & (end_cnt_d >= pers_need);

    // Gesture state machine
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (mode_on & gesture_enter) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                // Clearing mode is the only way out when threshold is zero
                if (!mode_on | exit_now) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            state_q        <= ST_IDLE;
            end_cnt_q      <= 3'h0;
            gesture_active <= 1'b0;
            gesture_exit   <= 1'b0;
            fifo_irq       <= 1'b0;
        end else if (ce) begin
            state_q        <= state_d;
            end_cnt_q      <= end_cnt_d;
            gesture_active <= state_d[1];
            gesture_exit   <= exit_now;
            // Level-driven: stays high while the FIFO holds enough
            fifo_irq       <= irq_en & (fifo_level >= irq_count);
        end
    end

    // Register writes
    always @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            thresh_q <= `GEXF_RST_THRESH;
            ctrl_q   <= `GEXF_RST_CTRL;
            mode_q   <= `GEXF_RST_MODE;
        end else if (ce & wb_wr) begin
            case (wb_idx)
                `GEXF_IDX_THRESH: thresh_q <= wb_dat_i[DW-1:0];
                `GEXF_IDX_CTRL:   ctrl_q   <= wb_dat_i[7:0];
                `GEXF_IDX_MODE:   mode_q   <= wb_dat_i[1:0];
                default:          mode_q   <= mode_q;
            endcase
        end
    end

    // Read mux; unmapped or unused bits read zero
    always @* begin
        rd_data = 32'h0000_0000;
        case (wb_idx)
            `GEXF_IDX_THRESH: rd_data[DW-1:0] = thresh_q;
            `GEXF_IDX_CTRL:   rd_data[7:0]    = ctrl_q;
            `GEXF_IDX_MODE:   rd_data[1:0]    = mode_q;
            `GEXF_IDX_STATUS: begin
                rd_data[`GEXF_ST_ACTIVE]                = gesture_active;
                rd_data[`GEXF_ST_IRQ]                   = fifo_irq;
                rd_data[`GEXF_ST_LVL_LO +: LW]          = fifo_level;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Every request answered on the first clock with ce high after it is seen
    always @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= wb_req;
            if (wb_req & ~wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule
`default_nettype wire

//--- rtl/gexf_defs.vh
`ifndef GEXF_DEFS_VH
`define GEXF_DEFS_VH

// Word indexes on the bus (byte address = index * 4)
`define GEXF_IDX_THRESH    2'h0
`define GEXF_IDX_CTRL      2'h1
`define GEXF_IDX_MODE      2'h2
`define GEXF_IDX_STATUS    2'h3

// Reset values
`define GEXF_RST_THRESH    8'h00
`define GEXF_RST_CTRL      8'h00
`define GEXF_RST_MODE      2'h0

// Control register fields
`define GEXF_FIFO_LVL_HI   7
`define GEXF_FIFO_LVL_LO   6
`define GEXF_MASK_HI       5
`define GEXF_MASK_LO       2
`define GEXF_PERS_HI       1
`define GEXF_PERS_LO       0

// Mode register fields
`define GEXF_MODE_ACTIVE   0
`define GEXF_MODE_IRQ_EN   1

// Status register fields
`define GEXF_ST_ACTIVE     0
`define GEXF_ST_IRQ        1
`define GEXF_ST_LVL_LO     8

// FIFO level codes and dataset counts
`define GEXF_LVL_CODE_1    2'h0
`define GEXF_LVL_CODE_4    2'h1
`define GEXF_LVL_CODE_8    2'h2
`define GEXF_LVL_COUNT_1   6'h01
`define GEXF_LVL_COUNT_4   6'h04
`define GEXF_LVL_COUNT_8   6'h08
`define GEXF_LVL_COUNT_16  6'h10

// Exit persistence codes and occurrences needed
`define GEXF_PERS_CODE_1   2'h0
`define GEXF_PERS_CODE_2   2'h1
`define GEXF_PERS_CODE_4   2'h2
`define GEXF_PERS_NEED_1   3'h1
`define GEXF_PERS_NEED_2   3'h2
`define GEXF_PERS_NEED_4   3'h4
`define GEXF_PERS_NEED_7   3'h7

`define GEXF_THRESH_OFF    8'h00

`endif

//--- rtl/gexf_exit_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "gexf_defs.vh"

module gexf_exit_detect #(
    parameter NDET = 4,
    parameter DW   = 8
) (
    input  wire [NDET*DW-1:0] det_data,
    input  wire [NDET-1:0]    det_mask,
    input  wire [DW-1:0]      threshold,
    output wire               gesture_end
);
    wire [NDET-1:0] below;

    genvar i;
    generate
        for (i = 0; i < NDET; i = i + 1) begin : g_det
            // Masked detector never blocks the end decision
            assign below[i] = det_mask[i] | (det_data[i*DW +: DW] < threshold);
        end
    endgenerate

    // Zero threshold disables exit entirely
    assign gesture_end = (&below) & (threshold != `GEXF_THRESH_OFF);

endmodule
`default_nettype wire

//--- rtl/gexf_fifo_level.v
`timescale 1ns/1ps
`default_nettype none
`include "gexf_defs.vh"

module gexf_fifo_level #(
    parameter LW    = 6,
    parameter DEPTH = 32
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          ce,
    input  wire          clear,
    input  wire          push,
    input  wire          pop,
    output reg  [LW-1:0] level_q
);
    localparam [LW-1:0] FULL = DEPTH[LW-1:0];
    localparam [LW-1:0] ONE  = {{(LW-1){1'b0}}, 1'b1};

    wire do_push = push & (level_q != FULL);
    wire do_pop  = pop & (level_q != {LW{1'b0}});
    reg  [LW-1:0] level_d;

    // Counts datasets in the FIFO
    always @* begin
        level_d = level_q;
        if (clear) begin
            level_d = {LW{1'b0}};
        end else if (do_push & ~do_pop) begin
            level_d = level_q + ONE;
        end else if (do_pop & ~do_push) begin
            level_d = level_q - ONE;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= {LW{1'b0}};
        end else if (ce) begin
            level_q <= level_d;
        end
    end

endmodule
`default_nettype wire

//--- verif/gexf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gexf_checker (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        det_valid,
    input wire logic [7:0]  det_north,
    input wire logic [7:0]  det_south,
    input wire logic [7:0]  det_west,
    input wire logic [7:0]  det_east,
    input wire logic        gesture_active,
    input wire logic        gesture_exit
);
    logic [7:0] th_q;
    logic [7:0] ctl_q;
    logic       take;
    logic       endc;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Shadow registers, so exit decisions can be predicted from ports alone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            th_q <= 8'h00;
            ctl_q <= 8'h00;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i[3:2] == 2'h0)
                th_q <= wb_dat_i[7:0];
            if (wb_adr_i[3:2] == 2'h1)
                ctl_q <= wb_dat_i[7:0];
        end
    end
    assign endc = th_q != 8'h00 && (ctl_q[2] || det_east < th_q) && (ctl_q[3] || det_west < th_q)
        && (ctl_q[4] || det_south < th_q) && (ctl_q[5] || det_north < th_q);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ack_taken_a: assert property (take |=> wb_ack_o) else $error("ack missing");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    end_exit_a: assert property (
        gesture_active && det_valid && ctl_q[1:0] == 2'h0 && endc |=> gesture_exit && !gesture_active)
        else $error("end did not exit");
    noend_hold_a: assert property (gesture_active && det_valid && !endc |=> !gesture_exit)
        else $error("exit without end");
    thr_zero_a: assert property (th_q == 8'h00 |=> !gesture_exit) else $error("exit at zero");
    exit_cause_a: assert property (gesture_exit |-> $past(gesture_active && det_valid && endc))
        else $error("exit without cause");
    exit_single_a: assert property (gesture_exit |=> !gesture_exit) else $error("exit too long");
    exit_drop_a: assert property (gesture_exit |-> !gesture_active) else $error("still active");
endmodule
bind gexf_top gexf_checker gexf_checker_inst (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .det_valid(det_valid), .det_north(det_north), .det_south(det_south),
    .det_west(det_west), .det_east(det_east), .gesture_active(gesture_active), .gesture_exit(gesture_exit));
`default_nettype wire

//--- verif/gexf_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gexf_tb_top;
    logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, enter = 1'b0;
    logic        dv = 1'b0, push = 1'b0, pop = 1'b0, ack, act, ext, irq;
    logic [3:0]  adr = 4'h0, sel = 4'hF, wsel = 4'hF, m;
    logic [31:0] wdat = 32'h0, v = 32'h0, d, rdat, rd;
    integer      n_errors = 0, n_checks = 0, seed = 64, i, k, t, need;
    always #12.5 clk = ~clk;
    gexf_top gexf_top_inst (.clk(clk), .arst_n(arst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .gesture_enter(enter), .det_valid(dv), .det_north(v[31:24]), .det_south(v[23:16]),
        .det_west(v[15:8]), .det_east(v[7:0]), .fifo_push(push), .fifo_pop(pop),
        .gesture_active(act), .gesture_exit(ext), .fifo_irq(irq));
    task end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] dat);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= wsel;
        wdat <= dat;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 9);
        if (ack !== 1'b1) begin
            n_errors++;
            $display("FAIL %0t bus timeout", $time);
            end_sim;
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task go;
        @(posedge clk);
        enter <= 1'b1;
        @(posedge clk);
        enter <= 1'b0;
        settle;
        chk(act, 1'b1);
    endtask
    // Data lines are inverted outside det_valid so stale values cannot pass
    task det(input logic [31:0] dat, input logic x);
        @(posedge clk);
        dv <= 1'b1;
        v <= dat;
        @(posedge clk);
        dv <= 1'b0;
        v <= ~dat;
        #1 chk(ext, x);
    endtask
    task fp(input logic p);
        @(posedge clk);
        push <= p;
        pop <= !p;
        @(posedge clk);
        push <= 1'b0;
        pop <= 1'b0;
    endtask
    function logic endf(input logic [3:0] mk, input logic [7:0] th, input logic [31:0] x);
        endf = th != 8'h00 && (mk[0] || x[7:0] < th) && (mk[1] || x[15:8] < th)
            && (mk[2] || x[23:16] < th) && (mk[3] || x[31:24] < th);
    endfunction
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 4; i++) begin
            wb(1'b0, 4'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        wsel = 4'hE;
        wb(1'b1, 4'h0, 32'hA5);
        wsel = 4'hF;
        wb(1'b1, 4'hC, 32'hFF);
        wb(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        $display("test regs done");
        wb(1'b1, 4'h0, 32'h40);
        wb(1'b1, 4'h8, 32'h1);
        wb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h40);
        wb(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h1);
        for (i = 0; i < 64; i++) begin
            k = $random(seed);
            m = (i < 16) ? 4'(i) : k[3:0];
            d = (i < 16) ? 32'h3F3F3F3F + (32'h1 << 8 * (i % 4)) : $random(seed) & 32'h7F7F7F7F;
            wb(1'b1, 4'h4, {26'h0, m, 2'h0});
            wb(1'b0, 4'h4, 32'h0);
            chk(rd, {26'h0, m, 2'h0});
            if (act !== 1'b1)
                go;
            det(d, endf(m, 8'h40, d));
        end
        $display("test mask done");
        for (i = 0; i < 4; i++) begin
            wb(1'b1, 4'h4, 32'(i));
            go;
            need = (i == 3) ? 7 : 1 << i;
            for (k = 1; k < need; k++)
                det(32'h0, 1'b0);
            det(32'hFFFFFFFF, 1'b0);
            for (k = 1; k < need; k++)
                det(32'h0, 1'b0);
            det(32'h0, 1'b1);
        end
        $display("test persistence done");
        wb(1'b1, 4'h0, 32'h0);
        go;
        for (k = 0; k < 8; k++)
            det(32'h0, 1'b0);
        wb(1'b1, 4'h8, 32'h0);
        settle;
        chk(act, 1'b0);
        // Entry request with mode off must be ignored
        @(posedge clk);
        enter <= 1'b1;
        @(posedge clk);
        enter <= 1'b0;
        settle;
        chk(act, 1'b0);
        $display("test zero threshold done");
        for (i = 0; i < 4; i++) begin
            need = (i == 0) ? 1 : 4 << (i - 1);
            wb(1'b1, 4'h8, 32'h0);
            wb(1'b1, 4'h4, 32'(i << 6));
            wb(1'b1, 4'h8, 32'h3);
            repeat (need - 1)
                fp(1'b1);
            settle;
            chk(irq, 1'b0);
            fp(1'b1);
            settle;
            chk(irq, 1'b1);
            wb(1'b0, 4'hC, 32'h0);
            chk(rd, 32'(need << 8 | 2));
            wb(1'b1, 4'h8, 32'h1);
            settle;
            chk(irq, 1'b0);
            wb(1'b1, 4'h8, 32'h3);
            fp(1'b0);
            settle;
            chk(irq, 1'b0);
        end
        $display("test fifo done");
        end_sim;
    end
endmodule
`default_nettype wire
